// ==== inc/itb_pkg.sv ====
/*
  Shared types and constants for the conditional-block, table-branch and
  breakpoint execution unit. Assumes a decoder upstream that fills instr_s.
*/
`default_nettype none
package itb_pkg;

  // Instruction classes seen by the unit
  typedef enum logic [2:0] {
    K_NORMAL = 3'h0,
    K_IF_THEN = 3'h1,
    K_TAB_BYTE = 3'h2,
    K_TAB_HALF = 3'h3,
    K_BREAK = 3'h4,
    K_COND_BRANCH = 3'h5
  } kind_e;

  // Condition flags
  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } flags_s;

  // Decoded instruction as handed over by the decoder
  typedef struct packed {
    kind_e kind;
    logic wide;
    logic sets_flags;
    logic [3:0] cond;
    logic [3:0] mask;
    logic base_is_counter;
    logic [7:0] imm8;
    logic [24:0] offset;
  } instr_s;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_TABLE = 3'b010,
    ST_HALT = 3'b100
  } state_e;

  // Condition code groups (upper three bits), low bit inverts
  localparam logic [2:0] CC_EQ = 3'h0;
  localparam logic [2:0] CC_CS = 3'h1;
  localparam logic [2:0] CC_MI = 3'h2;
  localparam logic [2:0] CC_VS = 3'h3;
  localparam logic [2:0] CC_HI = 3'h4;
  localparam logic [2:0] CC_GE = 3'h5;
  localparam logic [2:0] CC_GT = 3'h6;
  localparam logic [2:0] CC_ALWAYS = 3'h7;
  localparam logic [3:0] COND_ALWAYS = 4'he;

  localparam logic [7:0] IT_CLEAR = 8'h00;
  localparam logic [31:0] NARROW_LEN = 32'h0000_0002;
  localparam logic [31:0] WIDE_LEN = 32'h0000_0004;
  localparam int HALF_INDEX_SHIFT = 1;
  localparam int TABLE_OFFSET_SHIFT = 1;
  localparam int SHORT_OFFSET_BITS = 21;
  localparam int LONG_OFFSET_BITS = 25;

endpackage : itb_pkg
`default_nettype wire

// ==== rtl/cond_check.sv ====
/*
  Condition evaluator: four-bit condition code against the flags.
  Assumes the flags are stable in the cycle of evaluation.
*/
`timescale 1ns/1ps
`default_nettype none
module cond_check
  import itb_pkg::*;
(
  input wire logic [3:0] cond_in,
  input wire flags_s flags_in,
  output logic pass_out
);

  logic raw;

  // Group test, then optional inversion; the always group never inverts
  always_comb
  begin
    case (cond_in[3:1])
      CC_EQ: raw = flags_in.z;
      CC_CS: raw = flags_in.c;
      CC_MI: raw = flags_in.n;
      CC_VS: raw = flags_in.v;
      CC_HI: raw = flags_in.c & ~flags_in.z;
      CC_GE: raw = (flags_in.n == flags_in.v);
      CC_GT: raw = ~flags_in.z & (flags_in.n == flags_in.v);
      default: raw = 1'b1;
    endcase
    if (cond_in[3:1] != CC_ALWAYS && cond_in[0])
    begin
      pass_out = ~raw;
    end
    else
    begin
      pass_out = raw;
    end
  end

endmodule : cond_check
`default_nettype wire

// ==== rtl/it_state.sv ====
/*
  Conditional-block state: base condition group in [7:5], current instruction's inversion bit in [4], remaining switch mask
  in [3:0]. Assumes only one of load/advance acts per cycle from the core.
*/
`timescale 1ns/1ps
`default_nettype none
module it_state
  import itb_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic load_in,
  input wire logic [7:0] load_val_in,
  input wire logic advance_in,
  input wire logic clear_in,
  input wire logic restore_in,
  input wire logic [7:0] restore_val_in,
  output logic [7:0] state_out,
  output logic in_block_out
);

  logic [7:0] next_state;

  // Restore beats clear beats load beats advance
  always_comb
  begin
    next_state = state_out;
    if (restore_in)
    begin
      next_state = restore_val_in;
    end
    else if (clear_in)
    begin
      next_state = IT_CLEAR;
    end
    else if (load_in)
    begin
      next_state = load_val_in;
    end
    else if (advance_in)
    begin
      // Last instruction when only the terminator bit is left
      if (state_out[2:0] == 3'h0)
      begin
        next_state = IT_CLEAR;
      end
      else
      begin
        next_state = {state_out[7:5], state_out[3:0], 1'b0};
      end
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      state_out <= IT_CLEAR;
    end
    else
    begin
      state_out <= next_state;
    end
  end

  assign in_block_out = (state_out[3:0] != 4'h0);

endmodule : it_state
`default_nettype wire

// ==== rtl/itb_exec.sv ====
/*
  Execution unit for the if-then prefix, both table branches and the
  breakpoint. Assumes a decoder that presents one instruction at a time
  with valid/ready, a same-clock memory port for table reads, and a core
  that forms the link register and stacks the status word itself.
*/
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Prefix makes the next one to four instructions a conditional block.
// - Base condition governs the first; three switches govern the rest.
// - Each switch picks the base condition or its inverse.
// - Breakpoint inside a block executes even when its condition fails.
// - Exceptions between prefix and block instructions save block state.
// - Exception return into a block resumes it correctly.
// - Conditional branch works in and out of blocks, longer range inside.
// - Prefix and breakpoint leave the flags alone.
// - Table branches leave the flags alone.
// - Program counter as table base means byte after the instruction.
// - Halfword table index is shifted left by one.
// - Target is next address plus twice the unsigned table entry.
// - Breakpoint enters debug state.
// - Breakpoint immediate is eight bits, ignored, kept for the debugger.
module itb_exec
  import itb_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic instr_valid_in,
  input wire instr_s instr_in,
  input wire logic [31:0] instr_addr_in,
  input wire logic [31:0] base_reg_in,
  input wire logic [31:0] index_reg_in,
  input wire flags_s flags_in,
  input wire logic exc_entry_in,
  input wire logic exc_return_in,
  input wire logic [7:0] restore_itstate_in,
  input wire logic mem_ack_in,
  input wire logic [15:0] mem_rdata_in,
  input wire logic debug_resume_in,
  output logic instr_ready_out,
  output logic exec_out,
  output logic flags_we_out,
  output logic branch_valid_out,
  output logic [31:0] branch_target_out,
  output logic mem_req_out,
  output logic [31:0] mem_addr_out,
  output logic mem_half_out,
  output logic debug_enter_out,
  output logic debug_halted_out,
  output logic [7:0] break_imm_out,
  output logic [7:0] stacked_itstate_out,
  output logic [7:0] itstate_out,
  output logic in_block_out
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  state_e state;
  state_e next_state;
  logic accept;
  logic cond_pass;
  logic run;
  logic [3:0] eff_cond;
  logic [31:0] after_addr;
  logic [31:0] table_base;
  logic [31:0] table_index;
  logic [31:0] short_off;
  logic [31:0] long_off;
  logic [31:0] ret_addr;
  logic [31:0] next_ret_addr;
  logic next_exec;
  logic next_flags_we;
  logic next_branch_valid;
  logic [31:0] next_branch_target;
  logic next_mem_req;
  logic [31:0] next_mem_addr;
  logic next_mem_half;
  logic next_debug_enter;
  logic [7:0] next_break_imm;
  logic [7:0] next_stacked;
  logic exc_take;
  logic ret_take;
  logic it_load;
  logic it_adv;
  logic [31:0] table_entry;

  ////////////////////////////////////////////////////////////////////////
  // Block state and condition

  // Exceptions are only taken between instructions, never mid table fetch
  assign exc_take = (state == ST_IDLE) & exc_entry_in;
  assign ret_take = (state == ST_IDLE) & ~exc_entry_in & exc_return_in;
  assign instr_ready_out = (state == ST_IDLE) & ~exc_entry_in & ~exc_return_in;
  assign accept = instr_valid_in & instr_ready_out;
  // Nested prefix is software's fault; it then simply advances the block
  assign it_load = accept & ~in_block_out & (instr_in.kind == K_IF_THEN);
  assign it_adv = accept & in_block_out;

  it_state u_it_state (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .load_in(it_load),
    .load_val_in({instr_in.cond, instr_in.mask}),
    .advance_in(it_adv),
    .clear_in(exc_take),
    .restore_in(ret_take),
    .restore_val_in(restore_itstate_in),
    .state_out(itstate_out),
    .in_block_out(in_block_out)
  );

  // Inside a block the current switch position picks base or inverse
  always_comb
  begin
    if (in_block_out)
    begin
      eff_cond = itstate_out[7:4];
    end
    else if (instr_in.kind == K_COND_BRANCH)
    begin
      eff_cond = instr_in.cond;
    end
    else
    begin
      eff_cond = COND_ALWAYS;
    end
  end

  cond_check u_cond_check (
    .cond_in(eff_cond),
    .flags_in(flags_in),
    .pass_out(cond_pass)
  );

  assign run = cond_pass | (instr_in.kind == K_BREAK);

  ////////////////////////////////////////////////////////////////////////
  // Address arithmetic

  assign after_addr = instr_addr_in + (instr_in.wide ? WIDE_LEN : NARROW_LEN);
  assign table_base = instr_in.base_is_counter ? after_addr : base_reg_in;
  assign table_index = (instr_in.kind == K_TAB_HALF) ?
                       (index_reg_in << HALF_INDEX_SHIFT) : index_reg_in;
  // Only the low 21 offset bits reach outside a block
  assign short_off = {{(32 - SHORT_OFFSET_BITS){instr_in.offset[SHORT_OFFSET_BITS - 1]}},
                      instr_in.offset[SHORT_OFFSET_BITS - 1:0]};
  assign long_off = {{(32 - LONG_OFFSET_BITS){instr_in.offset[LONG_OFFSET_BITS - 1]}},
                     instr_in.offset};
  // Entry is unsigned, so the branch can only go forward
  assign table_entry = mem_half_out ? {16'h0000, mem_rdata_in} :
                       {24'h000000, mem_rdata_in[7:0]};

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb
  begin
    next_state = state;
    next_ret_addr = ret_addr;
    next_exec = 1'b0;
    next_flags_we = 1'b0;
    next_branch_valid = 1'b0;
    next_branch_target = branch_target_out;
    next_mem_req = mem_req_out;
    next_mem_addr = mem_addr_out;
    next_mem_half = mem_half_out;
    next_debug_enter = 1'b0;
    next_break_imm = break_imm_out;
    next_stacked = stacked_itstate_out;
    case (state)
      ST_IDLE:
      begin
        if (exc_take)
        begin
          next_stacked = itstate_out;
        end
        else if (accept)
        begin
          next_exec = run;
          // Prefix, table and breakpoint never write flags
          next_flags_we = run & instr_in.sets_flags &
                          (instr_in.kind == K_NORMAL);
          if (run)
          begin
            case (instr_in.kind)
              K_TAB_BYTE, K_TAB_HALF:
              begin
                next_mem_req = 1'b1;
                next_mem_addr = table_base + table_index;
                next_mem_half = (instr_in.kind == K_TAB_HALF);
                next_ret_addr = after_addr;
                next_state = ST_TABLE;
              end
              K_COND_BRANCH:
              begin
                next_branch_valid = 1'b1;
                next_branch_target = after_addr + (in_block_out ? long_off : short_off);
              end
              K_BREAK:
              begin
                next_debug_enter = 1'b1;
                next_break_imm = instr_in.imm8;
                next_state = ST_HALT;
              end
              default:
              begin
                next_state = ST_IDLE;
              end
            endcase
          end
        end
      end
      ST_TABLE:
      begin
        // Request holds until the memory answers
        if (mem_ack_in)
        begin
          next_mem_req = 1'b0;
          next_branch_valid = 1'b1;
          next_branch_target = ret_addr + (table_entry << TABLE_OFFSET_SHIFT);
          next_state = ST_IDLE;
        end
      end
      ST_HALT:
      begin
        if (debug_resume_in)
        begin
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      state <= ST_IDLE;
      ret_addr <= 32'h0000_0000;
      exec_out <= 1'b0;
      flags_we_out <= 1'b0;
      branch_valid_out <= 1'b0;
      branch_target_out <= 32'h0000_0000;
      mem_req_out <= 1'b0;
      mem_addr_out <= 32'h0000_0000;
      mem_half_out <= 1'b0;
      debug_enter_out <= 1'b0;
      break_imm_out <= 8'h00;
      stacked_itstate_out <= IT_CLEAR;
    end
    else
    begin
      state <= next_state;
      ret_addr <= next_ret_addr;
      exec_out <= next_exec;
      flags_we_out <= next_flags_we;
      branch_valid_out <= next_branch_valid;
      branch_target_out <= next_branch_target;
      mem_req_out <= next_mem_req;
      mem_addr_out <= next_mem_addr;
      mem_half_out <= next_mem_half;
      debug_enter_out <= next_debug_enter;
      break_imm_out <= next_break_imm;
      stacked_itstate_out <= next_stacked;
    end
  end

  assign debug_halted_out = (state == ST_HALT);

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_tbl_start;
    accept && run && (instr_in.kind == K_TAB_BYTE || instr_in.kind == K_TAB_HALF);
  endsequence
  sequence s_tbl_done;
    mem_req_out && mem_ack_in && (state == ST_TABLE);
  endsequence

  property p_it_load;
    it_load |=> (itstate_out == $past({instr_in.cond, instr_in.mask})) && in_block_out;
  endproperty
  a_it_load: assert property (p_it_load) else $error("block state not loaded");

  property p_block_len;
    (accept && in_block_out && itstate_out[2:0] == 3'h0 && !exc_take) |=> !in_block_out;
  endproperty
  a_block_len: assert property (p_block_len) else $error("block outlived last");

  // A resume pulse in the first halted cycle legally ends the halt one cycle later
  property p_break;
    (accept && instr_in.kind == K_BREAK) |=> debug_enter_out && exec_out && debug_halted_out
      ##1 (debug_halted_out || $past(debug_resume_in));
  endproperty
  a_break: assert property (p_break) else $error("breakpoint missed debug");

  property p_flags;
    (accept && instr_in.kind != K_NORMAL) |=> !flags_we_out;
  endproperty
  a_flags: assert property (p_flags) else $error("flags written");

  property p_tbl_addr;
    s_tbl_start |=> mem_req_out && (mem_addr_out == $past(table_base + table_index));
  endproperty
  a_tbl_addr: assert property (p_tbl_addr) else $error("bad table address");

  property p_tbl_target;
    s_tbl_done |=> branch_valid_out &&
      (branch_target_out == $past(ret_addr + (table_entry << TABLE_OFFSET_SHIFT)));
  endproperty
  a_tbl_target: assert property (p_tbl_target) else $error("bad table target");

  property p_tbl_flow;
    s_tbl_start ##1 (!mem_ack_in) [*2] |-> ##1 mem_req_out && !branch_valid_out;
  endproperty
  a_tbl_flow: assert property (p_tbl_flow) else $error("request dropped");

  property p_exc_save;
    exc_take |=> (stacked_itstate_out == $past(itstate_out)) && !in_block_out;
  endproperty
  a_exc_save: assert property (p_exc_save) else $error("state not stacked");

  property p_exc_restore;
    ret_take |=> itstate_out == $past(restore_itstate_in);
  endproperty
  a_exc_restore: assert property (p_exc_restore) else $error("state not restored");

  property p_short_range;
    (accept && cond_pass && !in_block_out && instr_in.kind == K_COND_BRANCH) |=>
      branch_valid_out && (branch_target_out == $past(after_addr + short_off));
  endproperty
  a_short_range: assert property (p_short_range) else $error("bad branch range");

  property p_imm;
    (accept && instr_in.kind == K_BREAK) |=> break_imm_out == $past(instr_in.imm8);
  endproperty
  a_imm: assert property (p_imm) else $error("immediate not kept");

endmodule : itb_exec
`default_nettype wire

// ==== sim/tb_top.sv ====
/*
  Self-checking bench for the if-then prefix, table branch and breakpoint unit.
  Assumes the unit answers on the cycle after it accepts an instruction and
  that table reads come back on the memory port whenever the bench acks them.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import itb_pkg::*;
;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic instr_valid_in = 1'b0;
  instr_s instr_in = '0;
  logic [31:0] instr_addr_in = 32'h0000_0000;
  logic [31:0] base_reg_in = 32'h0000_0000;
  logic [31:0] index_reg_in = 32'h0000_0000;
  flags_s flags_in = '0;
  logic exc_entry_in = 1'b0;
  logic exc_return_in = 1'b0;
  logic [7:0] restore_itstate_in = 8'h00;
  logic mem_ack_in = 1'b0;
  logic [15:0] mem_rdata_in = 16'h0000;
  logic debug_resume_in = 1'b0;
  logic instr_ready_out, exec_out, flags_we_out, branch_valid_out;
  logic [31:0] branch_target_out, mem_addr_out;
  logic mem_req_out, mem_half_out, debug_enter_out, debug_halted_out, in_block_out;
  logic [7:0] break_imm_out, stacked_itstate_out, itstate_out;
  int num_errors = 0;
  int comparisons = 0;
  logic [31:0] t_out;

  ////////////////////////////////////////////////////////////////////////////
  // Unit under test
  itb_exec dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .instr_valid_in(instr_valid_in), .instr_in(instr_in), .instr_addr_in(instr_addr_in),
    .base_reg_in(base_reg_in), .index_reg_in(index_reg_in), .flags_in(flags_in),
    .exc_entry_in(exc_entry_in), .exc_return_in(exc_return_in),
    .restore_itstate_in(restore_itstate_in), .mem_ack_in(mem_ack_in),
    .mem_rdata_in(mem_rdata_in), .debug_resume_in(debug_resume_in),
    .instr_ready_out(instr_ready_out), .exec_out(exec_out), .flags_we_out(flags_we_out),
    .branch_valid_out(branch_valid_out), .branch_target_out(branch_target_out),
    .mem_req_out(mem_req_out), .mem_addr_out(mem_addr_out), .mem_half_out(mem_half_out),
    .debug_enter_out(debug_enter_out), .debug_halted_out(debug_halted_out),
    .break_imm_out(break_imm_out), .stacked_itstate_out(stacked_itstate_out),
    .itstate_out(itstate_out), .in_block_out(in_block_out));

  // 200 MHz clock
  always #2.5 ref_clk_in = ~ref_clk_in;

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers; four-state compare so an unknown never matches
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  function automatic instr_s mk(input kind_e k, input logic [3:0] c, input logic [3:0] m);
    instr_s i;
    i = '0;
    i.kind = k;
    i.cond = c;
    i.mask = m;
    i.sets_flags = 1'b1;
    return i;
  endfunction : mk

  // Offer one instruction; ready is read at the falling edge, where it has settled
  task automatic issue(input instr_s i);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    instr_valid_in <= 1'b1;
    instr_in <= i;
    @(negedge ref_clk_in);
    while (instr_ready_out !== 1'b1 && n < 50)
    begin
      n++;
      @(negedge ref_clk_in);
    end
    if (n >= 50) check(32'h0, 32'h1);
    @(posedge ref_clk_in);
    instr_valid_in <= 1'b0;
    #1;
  endtask : issue

  task automatic setup(input logic [3:0] f, input logic [31:0] a, input logic [31:0] b,
    input logic [31:0] x);
    @(posedge ref_clk_in);
    flags_in <= f;
    instr_addr_in <= a;
    base_reg_in <= b;
    index_reg_in <= x;
  endtask : setup

  // One block member: outcome pulses and the block state left behind. A prefix carries
  // the state it should load; members carry the block's current suffix, others none
  task automatic step(input kind_e k, input logic e, input logic fw, input logic [7:0] st);
    instr_s i;
    if (k == K_IF_THEN)
    begin
      i = mk(k, st[7:4], st[3:0]);
    end
    else
    begin
      i = mk(k, in_block_out ? itstate_out[7:4] : COND_ALWAYS, 4'h0);
    end
    issue(i);
    check(32'(exec_out), 32'(e));
    check(32'(flags_we_out), 32'(fw));
    check(32'(itstate_out), 32'(st));
    check(32'(in_block_out), 32'(st[3:0] != 4'h0));
  endtask : step

  // Pulse a single-cycle control input and look one edge later
  task automatic resume();
    @(posedge ref_clk_in);
    debug_resume_in <= 1'b1;
    @(posedge ref_clk_in);
    debug_resume_in <= 1'b0;
    #1;
    check(32'(debug_halted_out), 32'h0);
    check(32'(instr_ready_out), 32'h1);
  endtask : resume

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_block3();
    setup(4'b0100, 32'h0000_0100, 32'h0, 32'h0);
    step(K_IF_THEN, 1'b1, 1'b0, 8'h06);
    step(K_NORMAL, 1'b1, 1'b1, 8'h0c);
    step(K_NORMAL, 1'b1, 1'b1, 8'h18);
    step(K_NORMAL, 1'b0, 1'b0, 8'h00);
    step(K_NORMAL, 1'b1, 1'b1, 8'h00);
    $display("block of three done");
  endtask : t_block3

  // Longest block, failing condition, breakpoint last
  task automatic t_block4();
    setup(4'b0000, 32'h0000_0200, 32'h0, 32'h0);
    issue(mk(K_IF_THEN, 4'h0, 4'h1));
    check(32'(itstate_out), 32'h01);
    step(K_NORMAL, 1'b0, 1'b0, 8'h02);
    step(K_NORMAL, 1'b0, 1'b0, 8'h04);
    step(K_NORMAL, 1'b0, 1'b0, 8'h08);
    step(K_BREAK, 1'b1, 1'b0, 8'h00);
    check(32'(debug_enter_out), 32'h1);
    check(32'(break_imm_out), 32'h00);
    resume();
    $display("block of four done");
  endtask : t_block4

  // Always as base: member runs whatever the flags say
  task automatic t_always();
    setup(4'b0000, 32'h0000_0300, 32'h0, 32'h0);
    step(K_IF_THEN, 1'b1, 1'b0, 8'he8);
    step(K_NORMAL, 1'b1, 1'b1, 8'h00);
    $display("always block done");
  endtask : t_always

  task automatic t_break();
    instr_s i;
    i = mk(K_BREAK, COND_ALWAYS, 4'h0);
    i.imm8 = 8'hff;
    setup(4'b1111, 32'h0000_0400, 32'h0, 32'h0);
    issue(i);
    check(32'(debug_enter_out), 32'h1);
    check(32'(debug_halted_out), 32'h1);
    check(32'(break_imm_out), 32'hff);
    check(32'(flags_we_out), 32'h0);
    @(posedge ref_clk_in);
    #1;
    check(32'(debug_enter_out), 32'h0);
    check(32'(instr_ready_out), 32'h0);
    resume();
    $display("breakpoint done");
  endtask : t_break

  // Offset bit 21 is dropped outside a block and kept inside it
  task automatic t_cbranch();
    instr_s i;
    i = mk(K_COND_BRANCH, 4'h0, 4'h0);
    i.offset = 25'h020_0000;
    setup(4'b0000, 32'h0000_1000, 32'h0, 32'h0);
    issue(i);
    check(32'(branch_valid_out), 32'h0);
    setup(4'b0100, 32'h0000_1000, 32'h0, 32'h0);
    issue(i);
    check(32'(branch_valid_out), 32'h1);
    check(branch_target_out, 32'h0000_1002);
    t_out = branch_target_out;
    issue(mk(K_IF_THEN, 4'h0, 4'h8));
    issue(i);
    check(32'(branch_valid_out), 32'h1);
    check(branch_target_out - t_out, 32'h0020_0000);
    $display("conditional branch done");
  endtask : t_cbranch

  // Table read with a stalling memory, then the forward branch
  task automatic t_table(input instr_s i, input logic [31:0] a, input logic h,
    input logic [15:0] d, input logic [31:0] tgt);
    issue(i);
    check(32'(flags_we_out), 32'h0);
    check(mem_addr_out, a);
    check(32'(mem_half_out), 32'(h));
    repeat (2) @(posedge ref_clk_in);
    #1;
    check(32'(mem_req_out), 32'h1);
    check(32'(instr_ready_out), 32'h0);
    @(posedge ref_clk_in);
    mem_ack_in <= 1'b1;
    mem_rdata_in <= d;
    @(posedge ref_clk_in);
    mem_ack_in <= 1'b0;
    mem_rdata_in <= ~d;
    #1;
    check(32'(branch_valid_out), 32'h1);
    check(branch_target_out, tgt);
    $display("table branch done");
  endtask : t_table

  // Exception in mid-block, then return into it
  task automatic t_exc();
    setup(4'b0100, 32'h0000_0500, 32'h0, 32'h0);
    step(K_IF_THEN, 1'b1, 1'b0, 8'h06);
    step(K_NORMAL, 1'b1, 1'b1, 8'h0c);
    @(posedge ref_clk_in);
    exc_entry_in <= 1'b1;
    #1;
    check(32'(instr_ready_out), 32'h0);
    @(posedge ref_clk_in);
    exc_entry_in <= 1'b0;
    #1;
    check(32'(stacked_itstate_out), 32'h0c);
    check(32'(itstate_out), 32'h00);
    step(K_NORMAL, 1'b1, 1'b1, 8'h00);
    @(posedge ref_clk_in);
    exc_return_in <= 1'b1;
    restore_itstate_in <= 8'h0c;
    @(posedge ref_clk_in);
    exc_return_in <= 1'b0;
    #1;
    check(32'(itstate_out), 32'h0c);
    step(K_NORMAL, 1'b1, 1'b1, 8'h18);
    step(K_NORMAL, 1'b0, 1'b0, 8'h00);
    $display("exception done");
  endtask : t_exc

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, reached from the main sequence or the watchdog
  task automatic stop_test();
    $display("Checks: %0d comparisons, %0d errors", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  // Whole run needs well under a thousand cycles; a hang is cut off here
  initial
  begin
    repeat (20000) @(posedge ref_clk_in);
    num_errors++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    instr_s tb;
    repeat (10) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    #1;
    check(32'(itstate_out), 32'h00);
    check(32'(instr_ready_out), 32'h1);
    t_block3();
    t_block4();
    t_always();
    t_break();
    t_cbranch();
    tb = mk(K_TAB_HALF, COND_ALWAYS, 4'h0);
    tb.wide = 1'b1;
    tb.base_is_counter = 1'b1;
    setup(4'b0000, 32'h0000_2000, 32'h0000_9000, 32'h3);
    t_table(tb, 32'h0000_200a, 1'b1, 16'hfffe, 32'h0002_2000);
    tb = mk(K_TAB_BYTE, COND_ALWAYS, 4'h0);
    setup(4'b0000, 32'h0000_4000, 32'h0000_3000, 32'h5);
    t_table(tb, 32'h0000_3005, 1'b0, 16'hab80, 32'h0000_4102);
    t_exc();
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
